// ===== dv/swd_host_model.sv
// host controller model: open-drain driver of the one-wire control pin
`timescale 1ns/100ps
module swd_host_model (
  input  wire logic clk,
  input  wire logic wire_lvl,
  output logic      pull_low
);
  // ==========================================================================
  // line timing in clock cycles
  localparam int GAP = 200;  // start and end-of-stream time, above 3.5 us

  initial pull_low = 1'b0;

  // pull the wire low (1) or release it to the pull-up (0) for n cycles
  task automatic hold(input bit p, input int n);
    pull_low <= p;
    repeat (n) @(posedge clk);
  endtask : hold

  // one byte: bit windows from fall to fall, then the closing fall held low
  task automatic send_byte(input logic [7:0] b, input int nbits, input int u, input bit bad);
    int i;
    for (i = 7; i > 7 - nbits; i--)
    begin
      if (bad && i == 3)
      begin
        hold(1'b1, u);  // equal times: meets neither threshold
        hold(1'b0, u);
      end
      else
      begin
        hold(1'b1, b[i] ? u : 2 * u);
        hold(1'b0, b[i] ? 2 * u : u);
      end
    end
    hold(1'b1, GAP);
  endtask : send_byte

  // full transfer; the data byte may be cut short or carry a bad bit
  task automatic frame(input logic [7:0] a, input logic [7:0] d, input int nbits,
                       input int u, input bit bad, input bit skip, output bit acked);
    int n;
    if (!skip)
      hold(1'b0, GAP);
    send_byte(a, 8, u, 1'b0);
    hold(1'b0, GAP);
    send_byte(d, nbits, u, bad);
    pull_low <= 1'b0;
    repeat (3) @(posedge clk);
    acked = !wire_lvl;
    n = 0;
    while (!wire_lvl && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
  endtask : frame
endmodule : swd_host_model

// ===== dv/testbench.sv
// testbench: random dimming transfers and register checks against a reference model
`timescale 1ns/100ps
module testbench;
  localparam int ACK_PC = 100;  // shortened acknowledge pulse

  logic        CLK;
  logic        RESET;
  logic        CTRL_OUT;
  logic        CTRL_OE;
  logic [7:0]  ADDR;
  logic [31:0] WDATA;
  logic        WR;
  logic        RD;
  logic [31:0] RDATA;
  logic [4:0]  BRIGHTNESS;
  logic        host_pull;
  logic        ctrl_wire;
  int          mismatches;
  int          checks;
  int          seed;
  int          oe_len;
  int          last_len;
  int          pulses;

  // ==========================================================================
  // design, host and the resolved wire with its pull-up
  assign ctrl_wire = host_pull ? 1'b0 : (CTRL_OE ? CTRL_OUT : 1'b1);

  swd_receiver #(.ACK_PULSE_CYC(ACK_PC)) u_dut (
    .CLK        (CLK),
    .RESET      (RESET),
    .CTRL_IN    (ctrl_wire),
    .CTRL_OUT   (CTRL_OUT),
    .CTRL_OE    (CTRL_OE),
    .ADDR       (ADDR),
    .WDATA      (WDATA),
    .WR         (WR),
    .RD         (RD),
    .RDATA      (RDATA),
    .BRIGHTNESS (BRIGHTNESS)
  );

  swd_host_model u_host (
    .clk      (CLK),
    .wire_lvl (ctrl_wire),
    .pull_low (host_pull)
  );

  // clock and acknowledge pulse monitor
  always #10 CLK = ~CLK;

  always @(posedge CLK)
  begin
    if (CTRL_OE)
      oe_len++;
    else if (oe_len != 0)
    begin
      last_len = oe_len;
      pulses++;
      oe_len = 0;
    end
  end

  // ==========================================================================
  // compare, bus and closing tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge CLK);
    WR    <= 1'b1;
    ADDR  <= a;
    WDATA <= v;
    @(posedge CLK);
    WR    <= 1'b0;
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge CLK);
    RD   <= 1'b1;
    ADDR <= a;
    @(posedge CLK);
    RD   <= 1'b0;
    #1 v = RDATA;
  endtask : bus_rd

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : finish_test

  // watchdog for a hung transfer
  initial
  begin
    repeat (90000) @(posedge CLK);
    mismatches++;
    finish_test();
  end

  // ==========================================================================
  // main sequence
  initial
  begin : main
    logic [31:0] r;
    logic [31:0] v;
    logic [7:0]  a;
    logic [7:0]  d;
    logic [4:0]  bright;
    bit          acked;
    bit          mal;
    bit          upd;
    bit          ack_en;
    bit          ackx;
    int          k;
    int          p0;
    CLK = 1'b0; RESET = 1'b1; ADDR = 8'h00; WDATA = 32'h0000_0000; WR = 1'b0; RD = 1'b0;
    mismatches = 0; checks = 0; seed = 93; oe_len = 0; last_len = 0; pulses = 0;
    bright = 5'h00; ack_en = 1'b1;
    repeat (16) @(posedge CLK);
    RESET <= 1'b0;
    // reset values and an unmapped place
    check(BRIGHTNESS, 32'h0000_0000);
    check(CTRL_OE, 32'h0000_0000);
    check(CTRL_OUT, 32'h0000_0000);
    bus_rd(8'h00, v); check(v, 32'h0000_0001);
    bus_rd(8'h04, v); check(v, 32'h0000_0000);
    bus_rd(8'h08, v); check(v, 32'h0000_0000);
    bus_wr(8'h0C, $random(seed));
    bus_rd(8'h0C, v); check(v, 32'h0000_0000);
    for (k = 0; k < 16; k++)
    begin
      r = $random(seed);
      a = (r[2:0] == 3'h0) ? (8'h72 ^ (8'h01 << r[5:3])) : 8'h72;
      d = $random(seed);
      if (r[7:6] != 2'h0 || k == 5 || k == 7)
        d[6:5] = 2'h0;
      if (k == 5 || k == 7 || k == 0)
        a = 8'h72;
      if (k == 9 || k == 12)
        ack_en = (k == 12);
      if (k == 9 || k == 12)
        bus_wr(8'h00, {31'h0000_0000, ack_en});
      p0 = pulses;
      u_host.frame(a, d, (k == 5) ? 7 : 8, 5 + int'(r[11:8]), k == 7, k == 0, acked);
      repeat (2) @(posedge CLK);
      mal = (k == 5 || k == 7);
      upd = !mal && a == 8'h72 && d[6:5] == 2'h0;
      // select bits gate the brightness, not the acknowledge
      ackx = !mal && a == 8'h72 && d[7] && ack_en;
      if (upd)
        bright = d[4:0];
      check(ctrl_wire, 32'h0000_0001);
      check(BRIGHTNESS, bright);
      check(acked, ackx);
      check(pulses - p0, ackx);
      if (ackx)
        check(last_len, ACK_PC);
      bus_rd(8'h04, v);
      check(v & 32'h0000_031F, (mal << 9) | (upd << 8) | bright);
      if (upd)
      begin
        bus_rd(8'h08, v);
        check(v & 32'h0000_FFFF, {d, a});
      end
      bus_wr(8'h04, 32'h0000_0300);
    end
    finish_test();
  end : main
endmodule : testbench

// ===== rtl/swd_bit_meter.sv
// module: measures low and high time between falling edges and decodes the bit
`timescale 1ns/100ps
module swd_bit_meter (
  input  wire logic                      clk,
  input  wire logic                      reset,
  input  wire logic                      line,
  input  wire logic                      fall,
  output logic [swd_pkg::CNT_W-1:0]      low_cnt,
  output logic [swd_pkg::CNT_W-1:0]      high_cnt,
  output logic                           bit_one,
  output logic                           bit_bad
);

  logic [swd_pkg::CNT_W-1:0] low_q;
  logic [swd_pkg::CNT_W-1:0] low_d;
  logic [swd_pkg::CNT_W-1:0] high_q;
  logic [swd_pkg::CNT_W-1:0] high_d;
  logic [swd_pkg::CNT_W-1:0] high_eff;
  logic                      bit_zero;

  // ==========================================================================
  // saturating increment
  function automatic logic [swd_pkg::CNT_W-1:0] sat_inc(input logic [swd_pkg::CNT_W-1:0] v);
    if (v == swd_pkg::CNT_MAX)
      sat_inc = v;
    else
      sat_inc = v + 1'b1;
  endfunction : sat_inc

  // window opens at a falling edge: both durations restart
  always_comb
  begin
    low_d  = low_q;
    high_d = high_q;
    if (fall)
    begin
      low_d  = '0; // RULE6
      high_d = '0; // RULE6
    end
    else if (!line)
      low_d = sat_inc(low_q);
    else
      high_d = sat_inc(high_q);
  end

  // duration registers
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      low_q  <= '0;
      high_q <= '0;
    end
    else
    begin
      low_q  <= low_d;
      high_q <= high_d;
    end
  end

  // ratio decision, read by the caller on the closing falling edge;
  // that edge's own cycle is still high but not yet in the count, so add it
  // here, otherwise an exact two-to-one bit would decode as bad
  assign high_eff = sat_inc(high_q); // RULE5
  assign bit_one  = ({1'b0, high_eff} >= {low_q, 1'b0}) && (low_q != '0); // RULE5
  assign bit_zero = ({1'b0, low_q} >= {high_eff, 1'b0}); // RULE5
  assign bit_bad  = !bit_one && !bit_zero; // RULE15
  assign low_cnt  = low_q;
  assign high_cnt = high_q;

  // ==========================================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_window_restart: assert property (fall |=> high_q == '0 && low_q <= 8'h01) // RULE6
    else $error("bit window did not restart at falling edge");
  a_ratio_one: assert property (bit_one |-> !bit_bad && high_q >= low_q) // RULE5
    else $error("one decoded without high time dominating");

endmodule : swd_bit_meter

// ===== rtl/swd_pkg.sv
// package: constants, field layout, register map and states of the one-wire dimming receiver
package swd_pkg;

  // ==========================================================================
  // clock and timing
  localparam int CLK_MHZ          = 50;
  localparam int START_TIME_NS    = 3500;  // least high time before a byte
  localparam int EOS_TIME_NS      = 3500;  // least low time closing a byte
  localparam int ACK_DELAY_NS     = 3500;  // wait from last falling edge to pulldown
  localparam int ACK_PULSE_US     = 900;   // longest pulldown time
  // least times round up, longest time rounds down
  localparam int START_CYC_I      = (START_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int EOS_CYC_I        = (EOS_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int ACK_DELAY_CYC_I  = (ACK_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int ACK_PULSE_CYC    = ACK_PULSE_US * CLK_MHZ;

  // ==========================================================================
  // duration counters
  localparam int             CNT_W         = 8;
  localparam logic [CNT_W-1:0] CNT_MAX     = 8'hFF;
  localparam logic [CNT_W-1:0] START_CYC   = CNT_W'(START_CYC_I);
  localparam logic [CNT_W-1:0] EOS_CYC     = CNT_W'(EOS_CYC_I);
  localparam logic [CNT_W-1:0] ACK_DLY_CYC = CNT_W'(ACK_DELAY_CYC_I);
  localparam int             ACK_CNT_W     = 16;

  // ==========================================================================
  // frame layout
  localparam logic [7:0] DEV_ADDR      = 8'h72;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int         ACK_REQ_BIT   = 7;
  localparam int         REG_SEL_HI    = 6;
  localparam int         REG_SEL_LO    = 5;
  localparam int         BRIGHT_W      = 5;

  // ==========================================================================
  // software register map
  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_STATUS    = 8'h04;
  localparam logic [7:0] REG_LAST      = 8'h08;
  localparam int         CTRL_ACK_EN   = 0;
  localparam logic       CTRL_ACK_RST  = 1'b1;
  localparam int         ST_OK_BIT     = 8;
  localparam int         ST_ERR_BIT    = 9;
  localparam int         LAST_DATA_LSB = 8;

  // ==========================================================================
  // receiver states
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_GAP  = 6'h04,
    ST_DATA = 6'h08,
    ST_ACKW = 6'h10,
    ST_ACK  = 6'h20
  } swd_state_e;

endpackage : swd_pkg

// ===== rtl/swd_receiver.sv
// module: one-wire dimming receiver with open-drain acknowledge and register port
//
// How it works
// (RULE1) bytes arrive most significant bit first; receiver shifts left.
// (RULE2) host holds wire high at least 3.5 us before each byte.
// (RULE3) if wire already high, address byte starts at next falling edge.
// (RULE4) host closes each byte with at least 3.5 us low.
// (RULE5) one when high at least twice low; zero when low twice high.
// (RULE6) each bit window runs from one falling edge to the next.
// (RULE7) acknowledge only if requested, address matches and both bytes clean.
// (RULE8) acknowledge starts 3.5 us after last falling edge, lasts at most 900 us.
// (RULE9) host keeps wire low during the delay, then releases it.
// (RULE10) host takes a low during the acknowledge as confirmation.
// (RULE11) host starts no new transfer before the acknowledge ends.
// (RULE12) host requests acknowledge only with an open-drain driver.
// (RULE13) first byte compared in full against the fixed address 72 hex.
// (RULE14) data byte: bit 7 ack request, bits 6-5 select, 4-0 brightness.
// (RULE15) brightness updates only on clean matched frame with zero select bits.
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
module swd_receiver #(
  parameter int ACK_PULSE_CYC = swd_pkg::ACK_PULSE_CYC
) (
  input  wire logic                          CLK,
  input  wire logic                          RESET,
  input  wire logic                          CTRL_IN,
  output logic                               CTRL_OUT,
  output logic                               CTRL_OE,
  input  wire logic [7:0]                    ADDR,
  input  wire logic [31:0]                   WDATA,
  input  wire logic                          WR,
  input  wire logic                          RD,
  output logic [31:0]                        RDATA,
  output logic [swd_pkg::BRIGHT_W-1:0]       BRIGHTNESS
);

  localparam logic [swd_pkg::ACK_CNT_W-1:0] ACK_LAST = swd_pkg::ACK_CNT_W'(ACK_PULSE_CYC - 1);

  // ==========================================================================
  // declarations
  logic                              sync1_q;
  logic                              sync2_q;
  logic                              sync3_q;
  logic                              lvl_q;
  logic                              lvl_d;
  logic                              fall;
  logic [swd_pkg::CNT_W-1:0]         low_cnt;
  logic [swd_pkg::CNT_W-1:0]         high_cnt;
  logic                              bit_one;
  logic                              bit_bad;
  swd_pkg::swd_state_e               state_q;
  swd_pkg::swd_state_e               state_d;
  logic [7:0]                        shift_q;
  logic [7:0]                        shift_d;
  logic [3:0]                        bits_q;
  logic [3:0]                        bits_d;
  logic                              err_q;
  logic                              err_d;
  logic [7:0]                        addr_q;
  logic [7:0]                        addr_d;
  logic [7:0]                        data_q;
  logic [7:0]                        data_d;
  logic [swd_pkg::BRIGHT_W-1:0]      bright_q;
  logic [swd_pkg::BRIGHT_W-1:0]      bright_d;
  logic [swd_pkg::ACK_CNT_W-1:0]     ack_cnt_q;
  logic [swd_pkg::ACK_CNT_W-1:0]     ack_cnt_d;
  logic                              oe_q;
  logic                              oe_d;
  logic                              ok_evt;
  logic                              err_evt;
  logic                              byte_ok;
  logic                              addr_hit;
  logic                              ack_en_q;
  logic                              ack_en_d;
  logic                              ok_flag_q;
  logic                              ok_flag_d;
  logic                              err_flag_q;
  logic                              err_flag_d;
  logic [31:0]                       rdata_q;
  logic [31:0]                       rdata_d;

  // ==========================================================================
  // pin input: three flops, a change counts once the last two agree
  always_comb
  begin
    lvl_d = lvl_q;
    if (sync2_q == sync3_q)
      lvl_d = sync3_q;
  end

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      sync3_q <= 1'b1;
      lvl_q   <= 1'b1;
    end
    else
    begin
      sync1_q <= CTRL_IN;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      lvl_q   <= lvl_d;
    end
  end

  assign fall = lvl_q && !lvl_d;

  // ==========================================================================
  // bit timing
  swd_bit_meter u_meter (
    .clk      (CLK),
    .reset    (RESET),
    .line     (lvl_q),
    .fall     (fall),
    .low_cnt  (low_cnt),
    .high_cnt (high_cnt),
    .bit_one  (bit_one),
    .bit_bad  (bit_bad)
  );

  // ==========================================================================
  // frame receiver: next state
  assign byte_ok  = (bits_q == swd_pkg::BITS_PER_BYTE) && !err_q;
  assign addr_hit = (addr_q == swd_pkg::DEV_ADDR); // RULE13

  always_comb
  begin
    state_d   = state_q;
    shift_d   = shift_q;
    bits_d    = bits_q;
    err_d     = err_q;
    addr_d    = addr_q;
    data_d    = data_q;
    bright_d  = bright_q;
    ack_cnt_d = '0;
    ok_evt    = 1'b0;
    err_evt   = 1'b0;
    case (state_q)
      swd_pkg::ST_IDLE:
      begin
        // line was high, so this edge opens the address byte
        if (fall)
        begin
          state_d = swd_pkg::ST_ADDR; // RULE3
          bits_d  = '0;
          err_d   = 1'b0;
        end
      end
      swd_pkg::ST_ADDR, swd_pkg::ST_DATA:
      begin
        if (fall)
        begin
          if (bits_q == swd_pkg::BITS_PER_BYTE)
            err_d = 1'b1; // ninth bit spoils the byte
          else
          begin
            shift_d = {shift_q[6:0], bit_one}; // RULE1
            bits_d  = bits_q + 1'b1; // RULE6
            if (bit_bad)
              err_d = 1'b1; // RULE15
          end
        end
        else if (!lvl_q && low_cnt >= swd_pkg::EOS_CYC)
        begin
          if (!byte_ok)
          begin
            err_evt = 1'b1;
            state_d = swd_pkg::ST_IDLE;
          end
          else if (state_q == swd_pkg::ST_ADDR)
          begin
            addr_d  = shift_q;
            state_d = swd_pkg::ST_GAP;
          end
          else
          begin
            data_d  = shift_q;
            state_d = swd_pkg::ST_IDLE;
            if (addr_hit && !shift_q[swd_pkg::REG_SEL_HI] && !shift_q[swd_pkg::REG_SEL_LO])
            begin
              bright_d = shift_q[swd_pkg::BRIGHT_W-1:0]; // RULE14 RULE15
              ok_evt   = 1'b1;
            end
            if (addr_hit && shift_q[swd_pkg::ACK_REQ_BIT] && ack_en_q)
              state_d = swd_pkg::ST_ACKW; // RULE7
          end
        end
        else if (lvl_q && high_cnt >= swd_pkg::START_CYC)
        begin
          err_evt = 1'b1; // long high inside a byte
          state_d = swd_pkg::ST_IDLE;
        end
      end
      swd_pkg::ST_GAP:
      begin
        // data byte needs a full start interval before its first edge
        if (fall)
        begin
          bits_d = '0;
          if (high_cnt >= swd_pkg::START_CYC)
            state_d = swd_pkg::ST_DATA;
          else
          begin
            err_evt = 1'b1;
            state_d = swd_pkg::ST_IDLE;
          end
        end
      end
      swd_pkg::ST_ACKW:
      begin
        if (lvl_q)
          state_d = swd_pkg::ST_IDLE; // host let go too early
        else if (low_cnt >= swd_pkg::ACK_DLY_CYC)
          state_d = swd_pkg::ST_ACK; // RULE8
      end
      swd_pkg::ST_ACK:
      begin
        ack_cnt_d = ack_cnt_q + 1'b1;
        if (ack_cnt_q == ACK_LAST)
          state_d = swd_pkg::ST_IDLE; // RULE8
      end
      default:
        state_d = swd_pkg::ST_IDLE;
    endcase
    oe_d = (state_d == swd_pkg::ST_ACK); // RULE7
  end

  // frame receiver: registers
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      state_q   <= swd_pkg::ST_IDLE;
      shift_q   <= '0;
      bits_q    <= '0;
      err_q     <= 1'b0;
      addr_q    <= '0;
      data_q    <= '0;
      bright_q  <= '0;
      ack_cnt_q <= '0;
      oe_q      <= 1'b0;
    end
    else
    begin
      state_q   <= state_d;
      shift_q   <= shift_d;
      bits_q    <= bits_d;
      err_q     <= err_d;
      addr_q    <= addr_d;
      data_q    <= data_d;
      bright_q  <= bright_d;
      ack_cnt_q <= ack_cnt_d;
      oe_q      <= oe_d;
    end
  end

  // open-drain pin: only ever pulls low
  assign CTRL_OUT   = 1'b0;
  assign CTRL_OE    = oe_q;
  assign BRIGHTNESS = bright_q;

  // ==========================================================================
  // register port: control, sticky status (write one clears, set wins), last frame
  always_comb
  begin
    ack_en_d   = ack_en_q;
    ok_flag_d  = ok_flag_q;
    err_flag_d = err_flag_q;
    rdata_d    = '0;
    if (WR && ADDR == swd_pkg::REG_CTRL)
      ack_en_d = WDATA[swd_pkg::CTRL_ACK_EN];
    if (WR && ADDR == swd_pkg::REG_STATUS)
    begin
      ok_flag_d  = ok_flag_q && !WDATA[swd_pkg::ST_OK_BIT];
      err_flag_d = err_flag_q && !WDATA[swd_pkg::ST_ERR_BIT];
    end
    ok_flag_d  = ok_flag_d || ok_evt;
    err_flag_d = err_flag_d || err_evt;
    if (RD)
    begin
      if (ADDR == swd_pkg::REG_CTRL)
        rdata_d[swd_pkg::CTRL_ACK_EN] = ack_en_q;
      else if (ADDR == swd_pkg::REG_STATUS)
      begin
        rdata_d[swd_pkg::BRIGHT_W-1:0] = bright_q;
        rdata_d[swd_pkg::ST_OK_BIT]    = ok_flag_q;
        rdata_d[swd_pkg::ST_ERR_BIT]   = err_flag_q;
      end
      else if (ADDR == swd_pkg::REG_LAST)
      begin
        rdata_d[7:0] = addr_q;
        rdata_d[swd_pkg::LAST_DATA_LSB +: 8] = data_q;
      end
    end
  end

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      ack_en_q   <= swd_pkg::CTRL_ACK_RST;
      ok_flag_q  <= 1'b0;
      err_flag_q <= 1'b0;
      rdata_q    <= '0;
    end
    else
    begin
      ack_en_q   <= ack_en_d;
      ok_flag_q  <= ok_flag_d;
      err_flag_q <= err_flag_d;
      rdata_q    <= rdata_d;
    end
  end

  assign RDATA = rdata_q;

  // ==========================================================================
  // checks
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  a_msb_shift: assert property ((state_q == swd_pkg::ST_ADDR) && fall && bits_q < 4'h8
      |=> shift_q[0] == $past(bit_one) && shift_q[7:1] == $past(shift_q[6:0])) // RULE1
    else $error("bit not shifted in at the low end");
  a_direct_addr: assert property ((state_q == swd_pkg::ST_IDLE) && fall
      |=> state_q == swd_pkg::ST_ADDR && bits_q == 4'h0) // RULE3
    else $error("address byte not opened by first falling edge");
  a_bad_bit: assert property ((state_q == swd_pkg::ST_DATA) && fall && bit_bad |=> err_q) // RULE15
    else $error("bad ratio bit not flagged");
  a_ack_gate: assert property ($rose(oe_q)
      |-> addr_q == 8'h72 && data_q[7] && !err_q && bits_q == 4'h8) // RULE7 RULE13
    else $error("acknowledge without all conditions");
  a_ack_delay: assert property ($rose(oe_q) |-> low_cnt >= 8'd175 && !lvl_q) // RULE8
    else $error("acknowledge before the delay");
  a_ack_length: assert property (oe_q |-> ack_cnt_q < 16'd45000) // RULE8
    else $error("acknowledge longer than allowed");
  a_ack_end: assert property (oe_q && ack_cnt_q == ACK_LAST |=> !oe_q && state_q == swd_pkg::ST_IDLE) // RULE8
    else $error("acknowledge did not end on time");
  a_bright_upd: assert property ($changed(bright_q)
      |-> addr_q == 8'h72 && !data_q[6] && !data_q[5] && bright_q == data_q[4:0]) // RULE14 RULE15
    else $error("brightness changed without clean matched frame");
  a_set_wins: assert property (err_evt && WR && ADDR == 8'h04 && WDATA[9] |=> err_flag_q)
    else $error("error event lost to clear");
  a_rd_unmapped: assert property (RD && ADDR > 8'h08 |=> RDATA == 32'h0000_0000)
    else $error("unmapped read not zero");

endmodule : swd_receiver
